// ---- bp_partner.sv ----
`timescale 1ns/1ps
module bp_partner
  import vme_arb_pkg::*;
(
  input  wire logic       mclk_in, // clock
  input  wire logic       rst_in,  // reset
  input  wire bp_out_t    dev_in,  // device drive
  input  wire logic [3:0] req_in,  // pulse: masters want bus
  output bp_in_t          bus_out, // resolved lines
  output logic [1:0]      got_out, // last level taken
  output logic [7:0]      n_out    // grants taken
);
  logic [3:0] pend_ff;
  logic [3:0] hold_ff;
  logic       ans;
  // a downstream interrupter answers once the chain leaves this slot
  assign ans = !dev_in.iackout_n && !dev_in.mst_oe_n && !dev_in.as_n && dev_in.ds_n != 2'h3;
  // wired lines, released ones float to the terminator level
  always_comb begin
    bus_out = '1;
    if (!dev_in.mst_oe_n) begin
      bus_out.a = dev_in.a[3:1];
      bus_out.as_n = dev_in.as_n;
      bus_out.ds_n = dev_in.ds_n;
      bus_out.lword_n = dev_in.lword_n;
      bus_out.iack_n = dev_in.iack_n;
    end
    bus_out.iackin_n = bus_out.iack_n;
    bus_out.dtack_n = dev_in.dtack_oe_n & !ans;
    bus_out.berr_n = dev_in.berr_oe_n;
    bus_out.br_n = dev_in.br_oe_n & ~pend_ff;
    bus_out.bbsy_n = dev_in.bbsy_oe_n & (hold_ff == 4'h0);
    // an upstream arbiter grants every requested level while the bus is free
    bus_out.bg_in_n = bus_out.br_n | {4{!bus_out.bbsy_n}};
    bus_out.sysfail_n = dev_in.sysfail_oe_n;
    bus_out.sysreset_n = dev_in.sysreset_oe_n;
    if (!dev_in.d_oe_n) bus_out.d = dev_in.d;
    else if (ans) bus_out.d = 32'hFFFF_FF3C;
  end
  // masters downstream take a passed grant and hold the bus a while
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pend_ff <= 4'h0;
      hold_ff <= 4'h0;
      got_out <= 2'h0;
      n_out <= 8'h0;
    end else begin
      pend_ff <= pend_ff | req_in;
      if (hold_ff != 4'h0) hold_ff <= hold_ff - 4'h1;
      for (int l = 0; l < 4; l++) begin
        if (hold_ff == 4'h0 && pend_ff[l] && !dev_in.bg_out_n[l]) begin
          pend_ff[l] <= 1'b0;
          hold_ff <= 4'h8;
          got_out <= 2'(l);
          n_out <= n_out + 8'h1;
        end
      end
    end
  end
endmodule

// ---- vme_arb_ctrl.sv ----
// Function
// - address-only cycle drives address, modifier, strobe; data strobes never asserted.
// - address-only cycle ends on its own, no acknowledge or bus error awaited.
// - four active-low request levels, level 3 ranks highest.
// - grant-in forwarded to grant-out unless this board claims that level.
// - requester at granted level keeps grant and asserts bus busy instead.
// - release-on-request owner keeps bus until another request appears.
// - release-when-done owner frees bus after each finished operation.
// - round robin: after granting x, level x-1 ranks first, wrapping 0 to 3.
// - fixed priority always grants highest pending level.
// - single-level mode honours level 3 requests only.
// - seven active-low interrupt levels, 1 lowest, 7 highest.
// - handler drives level on address 1..3 with acknowledge and address strobe.
// - handler encodes status width on data strobes.
// - slot-one driver uses acknowledge line as its chain input.
// - chain passed on unless pending interrupt at exactly that level.
// - matching board blocks chain and drives status onto data.
// - unsupported requested width answered with bus error.
// - release-on-acknowledge drops request after vector transfer.
// - release-on-register-access drops request only on register access.
// - system controller drives 16 MHz clock, never used for timing.
// - system controller asserts system reset at startup; used as card reset. Here it only returns bus logic to idle; registers keep their values.
// - any board may assert system fail; controller monitors it.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vme_arb_ctrl
  import vme_arb_pkg::*;
(
  input  wire logic     mclk_in,     // 40 MHz clock
  input  wire logic     rst_in,      // synchronous reset, high
  input  wire logic     sys_ctrl_in, // strap: board is system controller
  input  wire axi_req_t axi_req_in,  // axi4-lite requests
  output axi_rsp_t      axi_rsp_out, // axi4-lite responses
  input  wire bp_in_t   bp_in,       // backplane inputs, asynchronous
  output bp_out_t       bp_out       // backplane outputs and enables
);

  typedef struct packed {
    bp_in_t      s1;
    bp_in_t      s2;
    logic        strap1;
    logic        strap2;
    axi_rsp_t    rsp;
    bp_out_t     out;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [7:0]  ctrl;
    logic [31:0] addr;
    logic [5:0]  am;
    logic        cmd_pend;
    logic        cmd_iack;
    logic [2:0]  cmd_lvl;
    logic [1:0]  cmd_wid;
    logic        berr_seen;
    logic [31:0] iack_dat;
    logic [6:0]  irq_cfg;
    logic        irq_pend;
    logic [31:0] vector;
    mst_st_t     mst;
    logic [2:0]  ao_cnt;
    arb_st_t     arb;
    logic [1:0]  arb_lvl;
    logic [1:0]  rr_top;
    logic [3:0]  agnt;
    int_st_t     isr;
    logic        i_acked;
    logic [8:0]  rst_cnt;
    logic [5:0]  clk_acc;
  } state_t;

  state_t      s_ff;
  state_t      nxt_s;
  logic        sysctl;
  logic [3:0]  gin;
  logic [1:0]  lvl;
  logic        chain;
  logic        match;
  logic        irq_set;
  logic        irq_clr;
  logic        wr_fire;
  logic [3:0]  reqs;
  logic [2:0]  pick_res;
  logic [6:0]  acc_sum;

  // reset image of the whole state
  function automatic state_t init_state();
    state_t st;
    st                  = '0;
    st.s1               = '1;
    st.s2               = '1;
    st.rsp.awready      = 1'b1;
    st.rsp.wready       = 1'b1;
    st.rsp.arready      = 1'b1;
    st.out.as_n         = 1'b1;
    st.out.ds_n         = 2'h3;
    st.out.lword_n      = 1'b1;
    st.out.write_n      = 1'b1;
    st.out.iack_n       = 1'b1;
    st.out.mst_oe_n     = 1'b1;
    st.out.d_oe_n       = 1'b1;
    st.out.dtack_oe_n   = 1'b1;
    st.out.berr_oe_n    = 1'b1;
    st.out.br_oe_n      = 4'hF;
    st.out.bbsy_oe_n    = 1'b1;
    st.out.bg_out_n     = 4'hF;
    st.out.iackout_n    = 1'b1;
    st.out.irq_oe_n     = 7'h7F;
    st.out.sysfail_oe_n = 1'b1;
    st.out.sysreset_oe_n = 1'b1;
    st.rst_cnt          = SYSRESET_CYC;
    st.rr_top           = 2'h3;
    return st;
  endfunction

  // highest ranked request starting at top and rotating downward
  function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] top);
    logic [2:0] res;
    logic [1:0] l;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      l = 2'(top - 2'(i));
      if (req[l]) begin
        res = {1'b1, l};
      end
    end
    return res;
  endfunction

  // status width requested by strobes and long word
  function automatic logic [1:0] width_of(input logic [1:0] ds_n, input logic lword_n);
    if (ds_n == 2'h0) begin
      return lword_n ? WID_D16 : WID_D32;
    end
    return WID_D8;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_s    = s_ff;
    sysctl   = s_ff.strap2;
    lvl      = s_ff.ctrl[CTRL_LVL_LO +: 2];
    irq_set  = 1'b0;
    irq_clr  = 1'b0;
    wr_fire  = s_ff.aw_got & s_ff.w_got & ~s_ff.rsp.bvalid;
    reqs     = ~s_ff.s2.br_n;
    pick_res = 3'h0;
    acc_sum  = 7'h0;
    chain    = 1'b0;
    match    = 1'b0;

    // two-stage input synchronisers
    nxt_s.s1     = bp_in;
    nxt_s.s2     = s_ff.s1;
    nxt_s.strap1 = sys_ctrl_in;
    nxt_s.strap2 = s_ff.strap1;

    // effective grant-in: own arbiter in slot one, else the chain
    gin = sysctl ? s_ff.agnt : ~s_ff.s2.bg_in_n;

    // axi write address and data capture, in either order
    if (axi_req_in.awvalid && s_ff.rsp.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && s_ff.rsp.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = axi_req_in.wdata;
      nxt_s.wstrb = axi_req_in.wstrb;
    end
    if (s_ff.rsp.bvalid && axi_req_in.bready) begin
      nxt_s.rsp.bvalid = 1'b0;
    end

    // register write decode
    if (wr_fire) begin
      nxt_s.aw_got     = 1'b0;
      nxt_s.w_got      = 1'b0;
      nxt_s.rsp.bvalid = 1'b1;
      nxt_s.rsp.bresp  = RESP_OK;
      unique case (s_ff.awaddr)
        OFS_CTRL: nxt_s.ctrl = 8'(merge({24'h0, s_ff.ctrl}, s_ff.wdata, s_ff.wstrb));
        OFS_ADDR: nxt_s.addr = merge(s_ff.addr, s_ff.wdata, s_ff.wstrb);
        OFS_AM:   nxt_s.am = 6'(merge({26'h0, s_ff.am}, s_ff.wdata, s_ff.wstrb));
        OFS_CMD: begin
          if (s_ff.wstrb[0] && !s_ff.cmd_pend && (s_ff.wdata[CMD_AO] || s_ff.wdata[CMD_IACK])) begin
            nxt_s.cmd_pend = 1'b1;
            nxt_s.cmd_iack = s_ff.wdata[CMD_IACK];
            nxt_s.cmd_lvl  = s_ff.wdata[CMD_LVL_LO +: 3];
            nxt_s.cmd_wid  = s_ff.wdata[CMD_WID_LO +: 2];
          end
        end
        OFS_IRQ: begin
          nxt_s.irq_cfg = 7'(merge({25'h0, s_ff.irq_cfg}, s_ff.wdata, s_ff.wstrb)) & 7'h3F;
          irq_set       = s_ff.wstrb[0] & s_ff.wdata[IRQ_ARM];
          irq_clr       = s_ff.irq_cfg[IRQ_RORA];
        end
        OFS_VECTOR: nxt_s.vector = merge(s_ff.vector, s_ff.wdata, s_ff.wstrb);
        OFS_STATUS, OFS_IACKDAT: nxt_s.rsp.bresp = RESP_OK;
        default: nxt_s.rsp.bresp = RESP_ERR;
      endcase
    end

    // register read decode
    if (s_ff.rsp.rvalid && axi_req_in.rready) begin
      nxt_s.rsp.rvalid = 1'b0;
    end
    if (axi_req_in.arvalid && s_ff.rsp.arready) begin
      nxt_s.rsp.rvalid = 1'b1;
      nxt_s.rsp.rresp  = RESP_OK;
      nxt_s.rsp.rdata  = 32'h0;
      unique case (axi_req_in.araddr)
        OFS_CTRL:    nxt_s.rsp.rdata = {24'h0, s_ff.ctrl};
        OFS_ADDR:    nxt_s.rsp.rdata = s_ff.addr;
        OFS_AM:      nxt_s.rsp.rdata = {26'h0, s_ff.am};
        OFS_CMD:     nxt_s.rsp.rdata = {25'h0, s_ff.cmd_wid, s_ff.cmd_lvl, s_ff.cmd_iack, ~s_ff.cmd_iack};
        OFS_STATUS:  nxt_s.rsp.rdata = {25'h0, ~s_ff.s2.bbsy_n, sysctl, ~s_ff.s2.sysfail_n,
                                        s_ff.irq_pend, s_ff.berr_seen, ~s_ff.out.bbsy_oe_n,
                                        s_ff.cmd_pend || s_ff.mst != M_IDLE && s_ff.mst != M_OWN};
        OFS_IACKDAT: nxt_s.rsp.rdata = s_ff.iack_dat;
        OFS_IRQ: begin
          nxt_s.rsp.rdata = {25'h0, s_ff.irq_pend, s_ff.irq_cfg[5:0]};
          irq_clr         = irq_clr | s_ff.irq_cfg[IRQ_RORA];
        end
        OFS_VECTOR:  nxt_s.rsp.rdata = s_ff.vector;
        default:     nxt_s.rsp.rresp = RESP_ERR;
      endcase
    end

    // bus master: request, own, run cycle, release
    unique case (s_ff.mst)
      M_IDLE: begin
        if (s_ff.cmd_pend) begin
          nxt_s.out.br_oe_n[lvl] = 1'b0;
          nxt_s.mst              = M_REQ;
        end
      end
      M_REQ: begin
        if (gin[lvl]) begin
          nxt_s.out.br_oe_n   = 4'hF;
          nxt_s.out.bbsy_oe_n = 1'b0;
          nxt_s.mst           = M_START;
        end
      end
      M_OWN: begin
        if (s_ff.cmd_pend) begin
          nxt_s.mst = M_START;
        end else if (reqs != 4'h0) begin
          nxt_s.out.bbsy_oe_n = 1'b1;
          nxt_s.mst           = M_IDLE;
        end
      end
      M_START: begin
        nxt_s.cmd_pend     = 1'b0;
        nxt_s.out.mst_oe_n = 1'b0;
        nxt_s.out.am       = s_ff.am;
        nxt_s.out.write_n  = 1'b1;
        nxt_s.out.as_n     = 1'b0;
        if (s_ff.cmd_iack) begin
          nxt_s.out.a       = {28'h0, s_ff.cmd_lvl};
          nxt_s.out.iack_n  = 1'b0;
          nxt_s.out.ds_n    = (s_ff.cmd_wid == WID_D8) ? 2'h2 : 2'h0;
          nxt_s.out.lword_n = (s_ff.cmd_wid != WID_D32);
          nxt_s.mst         = M_IACK;
        end else begin
          nxt_s.out.a      = s_ff.addr[31:1];
          nxt_s.out.ds_n   = 2'h3;
          nxt_s.ao_cnt     = AO_CYC;
          nxt_s.mst        = M_AO;
        end
      end
      M_AO: begin
        nxt_s.ao_cnt = s_ff.ao_cnt - 3'h1;
        if (s_ff.ao_cnt == 3'h1) begin
          nxt_s.out.as_n     = 1'b1;
          nxt_s.out.mst_oe_n = 1'b1;
          nxt_s.mst          = M_END;
        end
      end
      M_IACK: begin
        if (!s_ff.s2.dtack_n || !s_ff.s2.berr_n) begin
          nxt_s.iack_dat     = s_ff.s2.d;
          nxt_s.berr_seen    = !s_ff.s2.berr_n;
          nxt_s.out.as_n     = 1'b1;
          nxt_s.out.ds_n     = 2'h3;
          nxt_s.out.iack_n   = 1'b1;
          nxt_s.out.lword_n  = 1'b1;
          nxt_s.out.mst_oe_n = 1'b1;
          nxt_s.mst          = M_END;
        end
      end
      M_END: begin
        if (s_ff.s2.dtack_n && s_ff.s2.berr_n) begin
          if (s_ff.ctrl[CTRL_ROR]) begin
            nxt_s.mst = M_OWN;
          end else begin
            nxt_s.out.bbsy_oe_n = 1'b1;
            nxt_s.mst           = M_IDLE;
          end
        end
      end
    endcase

    // grant daisy chain: pass unless claiming at that level
    for (int l = 0; l < 4; l++) begin
      nxt_s.out.bg_out_n[l] = !(gin[l] && !(s_ff.mst == M_REQ && lvl == 2'(l)));
    end

    // system arbiter, slot one only
    if (s_ff.ctrl[CTRL_MODE_LO +: 2] == MODE_SGL) begin
      reqs = reqs & 4'h8;
    end
    pick_res = pick(reqs, (s_ff.ctrl[CTRL_MODE_LO +: 2] == MODE_RRS) ? s_ff.rr_top : 2'h3);
    unique case (s_ff.arb)
      A_IDLE: begin
        if (sysctl && s_ff.s2.bbsy_n && pick_res[2]) begin
          nxt_s.arb_lvl             = pick_res[1:0];
          nxt_s.agnt[pick_res[1:0]] = 1'b1;
          nxt_s.arb                 = A_GRANT;
        end
      end
      A_GRANT: begin
        if (!s_ff.s2.bbsy_n) begin
          nxt_s.agnt   = 4'h0;
          nxt_s.rr_top = s_ff.arb_lvl - 2'h1;
          nxt_s.arb    = A_HELD;
        end else if (!reqs[s_ff.arb_lvl]) begin
          nxt_s.agnt = 4'h0;
          nxt_s.arb  = A_IDLE;
        end
      end
      A_HELD: begin
        if (s_ff.s2.bbsy_n) begin
          nxt_s.arb = A_IDLE;
        end
      end
      default: nxt_s.arb = A_IDLE;
    endcase

    // interrupter and acknowledge chain
    chain = sysctl ? !s_ff.s2.iack_n : !s_ff.s2.iackin_n;
    match = s_ff.irq_pend && s_ff.irq_cfg[2:0] != 3'h0 && s_ff.s2.a == s_ff.irq_cfg[2:0];
    unique case (s_ff.isr)
      I_IDLE: begin
        nxt_s.out.iackout_n = !(chain && !match);
        if (chain && match && !s_ff.s2.as_n && s_ff.s2.ds_n != 2'h3) begin
          nxt_s.out.iackout_n = 1'b1;
          if (width_of(s_ff.s2.ds_n, s_ff.s2.lword_n) <= s_ff.irq_cfg[IRQ_MAXW_LO +: 2]) begin
            nxt_s.out.d          = s_ff.vector;
            nxt_s.out.d_oe_n     = 1'b0;
            nxt_s.out.dtack_oe_n = 1'b0;
            nxt_s.i_acked        = 1'b1;
          end else begin
            nxt_s.out.berr_oe_n = 1'b0;
            nxt_s.i_acked       = 1'b0;
          end
          nxt_s.isr = I_RESP;
        end
      end
      I_RESP: begin
        if (s_ff.s2.as_n) begin
          nxt_s.out.d_oe_n     = 1'b1;
          nxt_s.out.dtack_oe_n = 1'b1;
          nxt_s.out.berr_oe_n  = 1'b1;
          irq_clr              = irq_clr | (s_ff.i_acked && !s_ff.irq_cfg[IRQ_RORA]);
          nxt_s.isr            = I_IDLE;
        end
      end
    endcase
    nxt_s.irq_pend = irq_set | (s_ff.irq_pend & ~irq_clr);
    for (int i = 1; i < 8; i++) begin
      nxt_s.out.irq_oe_n[i] = !(nxt_s.irq_pend && nxt_s.irq_cfg[2:0] == 3'(i));
    end

    // utility lines: fail, startup reset, system clock
    nxt_s.out.sysfail_oe_n = !s_ff.ctrl[CTRL_SYSFAIL];
    if (s_ff.rst_cnt != 9'h0) begin
      nxt_s.rst_cnt = s_ff.rst_cnt - 9'h1;
    end
    nxt_s.out.sysreset_oe_n = !(s_ff.strap2 && s_ff.rst_cnt != 9'h0);
    acc_sum = {1'b0, s_ff.clk_acc} + SYSCLK_STEP;
    if (!sysctl) begin
      nxt_s.clk_acc    = 6'h0;
      nxt_s.out.sysclk = 1'b0;
    end else if (acc_sum >= SYSCLK_MOD) begin
      nxt_s.clk_acc    = 6'(acc_sum - SYSCLK_MOD);
      nxt_s.out.sysclk = !s_ff.out.sysclk;
    end else begin
      nxt_s.clk_acc = acc_sum[5:0];
    end

    // backplane reset returns bus logic to idle
    if (!s_ff.s2.sysreset_n) begin
      nxt_s.mst           = M_IDLE;
      nxt_s.arb           = A_IDLE;
      nxt_s.isr           = I_IDLE;
      nxt_s.agnt          = 4'h0;
      nxt_s.cmd_pend      = 1'b0;
      nxt_s.out.mst_oe_n  = 1'b1;
      nxt_s.out.as_n      = 1'b1;
      nxt_s.out.ds_n      = 2'h3;
      nxt_s.out.iack_n    = 1'b1;
      nxt_s.out.br_oe_n   = 4'hF;
      nxt_s.out.bbsy_oe_n = 1'b1;
      nxt_s.out.d_oe_n    = 1'b1;
      nxt_s.out.dtack_oe_n = 1'b1;
      nxt_s.out.berr_oe_n = 1'b1;
    end

    // axi ready flags follow pending captures
    nxt_s.rsp.awready = !nxt_s.aw_got && !nxt_s.rsp.bvalid;
    nxt_s.rsp.wready  = !nxt_s.w_got && !nxt_s.rsp.bvalid;
    nxt_s.rsp.arready = !nxt_s.rsp.rvalid;
  end

  // single state register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_ff <= init_state();
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign axi_rsp_out = s_ff.rsp;
  assign bp_out      = s_ff.out;

endmodule

// ---- vme_arb_ctrl_asserts.sv ----
`timescale 1ns/1ps
module vme_arb_ctrl_asserts
  import vme_arb_pkg::*;
(
  input wire logic     mclk_in,     // clock
  input wire logic     rst_in,      // reset
  input wire logic     sys_ctrl_in, // strap
  input wire axi_req_t axi_req_in,  // axi requests
  input wire axi_rsp_t axi_rsp_out, // axi answers
  input wire bp_in_t   bp_in,       // lines in
  input wire bp_out_t  bp_out       // lines out
);
  logic [3:0] up_ff;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // cycles since reset, saturating
  always_ff @(posedge mclk_in)
    if (rst_in) up_ff <= 4'h0;
    else if (up_ff != 4'hF) up_ff <= up_ff + 4'h1;
  // master cycles and grant chain
  ao_nostrobe_a: assert property (!bp_out.mst_oe_n && bp_out.iack_n |-> bp_out.ds_n == 2'h3)
    else $error("data strobe in address-only cycle");
  ao_selfend_a: assert property ($fell(bp_out.as_n) && bp_out.iack_n |-> ##[3:5] bp_out.as_n)
    else $error("address-only cycle did not end");
  grant_kept_a: assert property (&(bp_out.br_oe_n | $past(bp_out.br_oe_n) | bp_out.bg_out_n))
    else $error("grant passed on while requesting");
  iack_start_a: assert property ($fell(bp_out.iack_n) |-> ##[0:2] !bp_out.as_n && !bp_out.mst_oe_n)
    else $error("acknowledge without address strobe");
  // interrupter answers
  chain_held_a: assert property (!bp_out.d_oe_n |-> bp_out.iackout_n)
    else $error("chain passed while returning status");
  answer_once_a: assert property (!bp_out.dtack_oe_n |-> bp_out.berr_oe_n && !bp_out.d_oe_n)
    else $error("acknowledge without data or with bus error");
  // utility lines
  sysreset_up_a: assert property (sys_ctrl_in && $fell(rst_in) |-> ##[1:8] !bp_out.sysreset_oe_n)
    else $error("no system reset at startup");
  sysclk_run_a: assert property (sys_ctrl_in && up_ff == 4'hF |-> ##[1:3] $changed(bp_out.sysclk))
    else $error("system clock stalled");
endmodule

bind vme_arb_ctrl vme_arb_ctrl_asserts chk_u (.mclk_in(mclk_in), .rst_in(rst_in), .sys_ctrl_in(sys_ctrl_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .bp_in(bp_in), .bp_out(bp_out));

// ---- vme_arb_pkg.sv ----
package vme_arb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_AM      = 8'h08;
  localparam logic [7:0] OFS_CMD     = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IACKDAT = 8'h14;
  localparam logic [7:0] OFS_IRQ     = 8'h18;
  localparam logic [7:0] OFS_VECTOR  = 8'h1C;
  // ctrl fields
  localparam int CTRL_ROR     = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_LVL_LO  = 3;
  localparam int CTRL_SYSFAIL = 5;
  // cmd fields
  localparam int CMD_AO       = 0;
  localparam int CMD_IACK     = 1;
  localparam int CMD_LVL_LO   = 2;
  localparam int CMD_WID_LO   = 5;
  // irq register fields
  localparam int IRQ_LVL_LO   = 0;
  localparam int IRQ_RORA     = 3;
  localparam int IRQ_MAXW_LO  = 4;
  localparam int IRQ_ARM      = 6;
  // arbitration modes and status widths
  localparam logic [1:0] MODE_RRS = 2'h0;
  localparam logic [1:0] MODE_PRI = 2'h1;
  localparam logic [1:0] MODE_SGL = 2'h2;
  localparam logic [1:0] WID_D8   = 2'h0;
  localparam logic [1:0] WID_D16  = 2'h1;
  localparam logic [1:0] WID_D32  = 2'h2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // timing
  localparam int MCLK_MHZ      = 40;
  localparam int SYSCLK_MHZ    = 16;
  localparam logic [6:0] SYSCLK_STEP = 7'(2 * SYSCLK_MHZ);
  localparam logic [6:0] SYSCLK_MOD  = 7'(MCLK_MHZ);
  localparam int AO_HOLD_NS    = 100;
  localparam logic [2:0] AO_CYC = 3'((AO_HOLD_NS * MCLK_MHZ + 999) / 1000);
  localparam int SYSRESET_US   = 10;
  localparam logic [8:0] SYSRESET_CYC = 9'(SYSRESET_US * MCLK_MHZ);

  typedef enum logic [2:0] {M_IDLE, M_REQ, M_OWN, M_START, M_AO, M_IACK, M_END} mst_st_t;
  typedef enum logic [1:0] {A_IDLE, A_GRANT, A_HELD} arb_st_t;
  typedef enum logic {I_IDLE, I_RESP} int_st_t;

  typedef struct packed {
    logic [3:1]  a;
    logic        as_n;
    logic [1:0]  ds_n;
    logic        lword_n;
    logic        iack_n;
    logic        iackin_n;
    logic        dtack_n;
    logic        berr_n;
    logic [3:0]  br_n;
    logic [3:0]  bg_in_n;
    logic        bbsy_n;
    logic        sysfail_n;
    logic        sysreset_n;
    logic [31:0] d;
  } bp_in_t;

  typedef struct packed {
    logic [31:1] a;
    logic [5:0]  am;
    logic        as_n;
    logic [1:0]  ds_n;
    logic        lword_n;
    logic        write_n;
    logic        iack_n;
    logic        mst_oe_n;
    logic [31:0] d;
    logic        d_oe_n;
    logic        dtack_n;
    logic        dtack_oe_n;
    logic        berr_n;
    logic        berr_oe_n;
    logic [3:0]  br_n;
    logic [3:0]  br_oe_n;
    logic        bbsy_n;
    logic        bbsy_oe_n;
    logic [3:0]  bg_out_n;
    logic        iackout_n;
    logic [7:1]  irq_n;
    logic [7:1]  irq_oe_n;
    logic        sysfail_n;
    logic        sysfail_oe_n;
    logic        sysreset_n;
    logic        sysreset_oe_n;
    logic        sysclk;
  } bp_out_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage

// ---- vme_arbitration_interrupt_chain_tb.sv ----
`timescale 1ns/1ps
module vme_arbitration_interrupt_chain_tb;
  import vme_arb_pkg::*;
  logic mclk_in, rst_in, sctl;
  axi_req_t req;
  axi_rsp_t rsp;
  bp_in_t bpi;
  bp_out_t bpo;
  logic [3:0] mreq;
  logic [1:0] got;
  logic [7:0] ngr, seen;
  logic [31:0] rv;
  int n_fail, cmp_count;
  vme_arb_ctrl dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .sys_ctrl_in(sctl), .axi_req_in(req),
    .axi_rsp_out(rsp), .bp_in(bpi), .bp_out(bpo));
  bp_partner far_u (.mclk_in(mclk_in), .rst_in(rst_in), .dev_in(bpo), .req_in(mreq), .bus_out(bpi),
    .got_out(got), .n_out(ngr));
  // 40 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic results;
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // axi write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OK);
    @(posedge mclk_in);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk(32'(rsp.bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OK);
    @(posedge mclk_in);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rv = rsp.rdata;
    chk(32'(rsp.rresp), 32'(er));
  endtask
  // read until the masked bits match the expected value or 200 reads pass, then compare
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int i;
    i = 0;
    do begin
      rd(a);
      i++;
    end while ((rv & m) !== e && i < 200);
    chk(rv & m, e);
  endtask
  // wait for a downstream master to take a new grant
  task automatic grant(input logic [1:0] e);
    int i;
    i = 0;
    while (ngr === seen && i < 300) begin
      @(posedge mclk_in);
      i++;
    end
    chk(32'({ngr !== seen, got}), 32'({1'b1, e}));
    seen = ngr;
  endtask
  task automatic req_m(input logic [3:0] m);
    @(posedge mclk_in);
    mreq <= m;
    @(posedge mclk_in);
    mreq <= 4'h0;
  endtask
  // main sequence
  initial begin
    rst_in = 1'b1;
    sctl = 1'b1;
    req = '0;
    mreq = 4'h0;
    seen = 8'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (430) @(posedge mclk_in);
    rd(OFS_CTRL);
    chk(rv, 32'h0);
    rd(OFS_STATUS);
    chk(rv, 32'h20);
    rd(8'h20, RESP_ERR);
    wr(8'h24, 32'h1, RESP_ERR);
    wr(OFS_CTRL, 32'h20);
    poll(OFS_STATUS, 32'h10, 32'h10);
    // fixed priority, then rotation
    wr(OFS_CTRL, 32'h02);
    req_m(4'h5);
    grant(2'h2);
    grant(2'h0);
    wr(OFS_CTRL, 32'h00);
    req_m(4'h8);
    grant(2'h3);
    req_m(4'hA);
    grant(2'h1);
    grant(2'h3);
    // address-only at a level shared with a downstream master, release when done
    wr(OFS_ADDR, 32'h0000_1230);
    wr(OFS_AM, 32'h0D);
    wr(OFS_CTRL, 32'h12);
    wr(OFS_CMD, 32'h1);
    req_m(4'h4);
    grant(2'h2);
    poll(OFS_STATUS, 32'h3, 32'h0);
    // acknowledge served by this board's own interrupter at level 5
    wr(OFS_VECTOR, 32'hA5);
    wr(OFS_IRQ, 32'h65);
    poll(OFS_STATUS, 32'h8, 32'h8);
    chk(32'(bpo.irq_oe_n), 32'h6F);
    wr(OFS_CMD, 32'h16);
    poll(OFS_STATUS, 32'hD, 32'h0);
    chk(32'(bpo.irq_oe_n), 32'h7F);
    rd(OFS_IACKDAT);
    chk(rv & 32'hFF, 32'hA5);
    // other level: chain passes downstream
    wr(OFS_IRQ, 32'h65);
    wr(OFS_CMD, 32'h12);
    poll(OFS_STATUS, 32'hD, 32'h8);
    rd(OFS_IACKDAT);
    chk(rv & 32'hFF, 32'h3C);
    // width too wide, then release on register access
    wr(OFS_IRQ, 32'h4D);
    wr(OFS_CMD, 32'h56);
    poll(OFS_STATUS, 32'hD, 32'hC);
    wr(OFS_IRQ, 32'h6D);
    wr(OFS_CMD, 32'h36);
    poll(OFS_STATUS, 32'hD, 32'h8);
    rd(OFS_IRQ);
    rd(OFS_STATUS);
    chk(rv & 32'h8, 32'h0);
    // release on request
    wr(OFS_CTRL, 32'h13);
    wr(OFS_CMD, 32'h1);
    poll(OFS_STATUS, 32'h3, 32'h2);
    repeat (20) @(posedge mclk_in);
    rd(OFS_STATUS);
    chk(rv & 32'h2, 32'h2);
    req_m(4'h1);
    grant(2'h0);
    poll(OFS_STATUS, 32'h2, 32'h0);
    // single level: only level 3 honoured
    wr(OFS_CTRL, 32'h04);
    req_m(4'h2);
    repeat (60) @(posedge mclk_in);
    chk(32'(ngr), 32'(seen));
    req_m(4'h8);
    grant(2'h3);
    // board out of slot one: grants arrive on grant-in and pass down the chain
    @(posedge mclk_in);
    sctl <= 1'b0;
    grant(2'h1);
    wr(OFS_CMD, 32'h1);
    poll(OFS_STATUS, 32'h23, 32'h0);
    results;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    results;
  end
endmodule
